// ### pkg/nand_chain_pkg.sv
// Shared constants and carrier types for the pin chain test logic
package nand_chain_pkg;

    // Number of pins that feed the chain
    localparam int unsigned CHAIN_LEN = 17;

    // Chain position of each pin, first position is the far end
    localparam int unsigned IDX_LAMP_G4_A          = 0;
    localparam int unsigned IDX_LAMP_G4_B          = 1;
    localparam int unsigned IDX_LAMP_G3_A          = 2;
    localparam int unsigned IDX_LAMP_G3_B          = 3;
    localparam int unsigned IDX_TIMING_GPIO_PIN    = 4;
    localparam int unsigned IDX_LAMP_G2_A          = 5;
    localparam int unsigned IDX_LAMP_G2_B          = 6;
    localparam int unsigned IDX_POWER_EVENT_PIN    = 7;
    localparam int unsigned IDX_SYNC_CLOCK_OUT_PIN = 8;
    localparam int unsigned IDX_SERIAL_OUT_PIN     = 9;
    localparam int unsigned IDX_SERIAL_IN_DATA_PIN = 10;
    localparam int unsigned IDX_SERIAL_SELECT_PIN  = 11;
    localparam int unsigned IDX_SERIAL_CLOCK_PIN   = 12;
    localparam int unsigned IDX_LAMP_G5_A          = 13;
    localparam int unsigned IDX_LAMP_G5_B          = 14;
    localparam int unsigned IDX_LAMP_G1_A          = 15;
    localparam int unsigned IDX_LAMP_G1_B          = 16;

    typedef logic [CHAIN_LEN-1:0] pin_vec_t;

    // Strap word is {lamp_g2_b, lamp_g2_a, lamp_g4_a}
    typedef logic [2:0] strap_t;
    localparam strap_t CHAIN_STRAP = 3'h0;

    // Reset and idle values
    localparam pin_vec_t PIN_ALL_OFF = 17'h00000;
    localparam pin_vec_t PIN_ALL_ON  = 17'h1ffff;
    localparam strap_t   STRAP_RST   = 3'h0;
    localparam logic     IRQ_IDLE    = 1'b1;

    // Drive bundle for a group of two-way pins
    typedef struct packed {
        pin_vec_t dat;
        pin_vec_t oe;
    } pad_drive_s;

    // Operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_STRAP = 3'b001,
        MODE_FUNC  = 3'b010,
        MODE_CHAIN = 3'b100
    } mode_e;

endpackage : nand_chain_pkg

// ### rtl/nand_chain_core.sv
// Combinational chain of nested NAND gates over the test pins
`timescale 1ns/1ps
module nand_chain_core
    import nand_chain_pkg::*;
(
    input  wire pin_vec_t pin_i,
    output logic          chain_o
);

    // Each pin meets one gate; a low pin forces its stage high and masks
    // everything farther out, so a new low pin flips the end result only when no other low pin lies nearer the output
    always_comb begin
        logic stage;
        stage = 1'b1;
        for (int i = 0; i < CHAIN_LEN; i++) begin
            stage = ~(stage & pin_i[i]);
        end
        // Final inversion makes the all-high case read high
        chain_o = ~stage;
    end

endmodule : nand_chain_core

// ### rtl/io_nand_chain_test.sv
// Pin chain test mode: strap capture, pin ownership and chain output
`timescale 1ns/1ps
module io_nand_chain_test
    import nand_chain_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire pin_vec_t   pad_in_i,
    output pad_drive_s      pad_o,
    output logic            irq_pad_o,
    output logic            irq_pad_oe_o,
    input  wire pad_drive_s func_drive_i,
    input  wire logic       func_irq_n_i,
    output pin_vec_t        func_in_o,
    output logic            chain_mode_o
);

    // Operation overview
    //
    // The block sits between the pad ring and the normal core logic of the
    // seventeen chain pins and of irq_out_pin. After reset it spends one
    // cycle in a strap phase, with every pin released, and reads the three
    // lamp strap pins. If they show the chain strap code the block enters
    // chain test mode and stays there until the next reset; otherwise it
    // hands the pins to the core for normal use.
    //
    // In chain test mode:
    //   - every chain pin is released, so the board tester alone sets it
    //   - the core sees an idle all-high pin word, so its normal functions
    //     react to nothing the tester does
    //   - irq_out_pin is driven with the end of the NAND chain, one clock
    //     later than the pins, which is far below any board tester step
    //
    // Limitation: the strap code is taken only once per reset. A board that
    // changes the strap pins later stays in the mode that was first chosen.
    //
    // Trade-off: the chain result is registered so that every output comes
    // from a flip-flop. The price is one cycle of latency, and the pin level
    // must be settled for one full clock before the tester looks.
    //
    // Chain positions, first position is the innermost gate:
    //   0  lamp_g4_a            9  serial_out_pin
    //   1  lamp_g4_b           10  serial_in_data_pin
    //   2  lamp_g3_a           11  serial_select_pin
    //   3  lamp_g3_b           12  serial clock pin
    //   4  timing gpio pin     13  lamp_g5_a
    //   5  lamp_g2_a           14  lamp_g5_b
    //   6  lamp_g2_b           15  lamp_g1_a
    //   7  power_event_pin     16  lamp_g1_b
    //   8  sync_clock_out_pin
    //
    // Strap word is {lamp_g2_b, lamp_g2_a, lamp_g4_a}; those pins are also
    // chain inputs, so the tester must set them high once the mode is taken.

    // True when a strap word selects chain test mode; used for both the
    // mode choice and the registered mode flag so they cannot disagree
    function automatic logic strap_is_chain_f(strap_t s);
        return (s == CHAIN_STRAP);
    endfunction : strap_is_chain_f

    // Whole state of the block
    typedef struct packed {
        logic     chain;
        mode_e    mode;
        strap_t   strap;
        pin_vec_t pad_dat;
        pin_vec_t pad_oe;
        logic     irq_lvl;
        logic     irq_oe;
        pin_vec_t core_in;
    } tst_state_s;

    localparam tst_state_s STATE_RST = '{
        chain:   1'b0,
        mode:    MODE_STRAP,
        strap:   STRAP_RST,
        pad_dat: PIN_ALL_OFF,
        pad_oe:  PIN_ALL_OFF,
        irq_lvl: IRQ_IDLE,
        irq_oe:  1'b0,
        core_in: PIN_ALL_ON
    };

    tst_state_s state_r;
    tst_state_s state_nxt;
    logic       chain_lvl;
    strap_t     strap_now;

    // The gate chain itself stays purely combinational
    nand_chain_core u_chain (
        .pin_i   (pad_in_i),
        .chain_o (chain_lvl)
    );

    // Strap word as seen on the three lamp pins
    assign strap_now = {pad_in_i[IDX_LAMP_G2_B],
                        pad_in_i[IDX_LAMP_G2_A],
                        pad_in_i[IDX_LAMP_G4_A]};

    // Next state; mode is fixed until the next reset since straps are
    // sampled only once, which keeps a test run from dropping out
    always_comb begin
        state_nxt = state_r;
        case (state_r.mode)
            MODE_STRAP: begin
                // Pins are released during reset so straps read cleanly
                state_nxt.strap = strap_now;
                // Flag kept apart from the mode so the output is a plain flop
                state_nxt.chain = strap_is_chain_f(strap_now);
                if (strap_is_chain_f(strap_now)) begin
                    state_nxt.mode = MODE_CHAIN;
                end else begin
                    state_nxt.mode = MODE_FUNC;
                end
            end
            MODE_FUNC: begin
                // Normal use: pads, irq pin and core see each other through
                // one register stage, so timing matches in both directions
                state_nxt.pad_dat = func_drive_i.dat;
                state_nxt.pad_oe  = func_drive_i.oe;
                state_nxt.irq_lvl = func_irq_n_i;
                state_nxt.irq_oe  = 1'b1;
                state_nxt.core_in = pad_in_i;
            end
            MODE_CHAIN: begin
                // Chain pins float so the tester alone drives them
                state_nxt.pad_dat = PIN_ALL_OFF;
                state_nxt.pad_oe  = PIN_ALL_OFF;
                // Core sees idle inputs; normal functions stay quiet
                state_nxt.core_in = PIN_ALL_ON;
                // One flop of delay, far below any board tester step
                state_nxt.irq_lvl = chain_lvl;
                state_nxt.irq_oe  = 1'b1;
            end
            default: begin
                state_nxt = STATE_RST;
            end
        endcase
    end

    // State register; reset loads constants only
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // All outputs straight from the state register
    assign pad_o.dat    = state_r.pad_dat;
    assign pad_o.oe     = state_r.pad_oe;
    assign irq_pad_o    = state_r.irq_lvl;
    assign irq_pad_oe_o = state_r.irq_oe;
    assign func_in_o    = state_r.core_in;
    assign chain_mode_o = state_r.chain;

endmodule : io_nand_chain_test

// ### test/io_nand_chain_test_properties.sv
// Port checks for the pin chain test block
`timescale 1ns/1ps
module io_nand_chain_test_properties
    import nand_chain_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       arst_n_i,
    input wire pin_vec_t   pad_in_i,
    input wire pad_drive_s pad_o,
    input wire logic       irq_pad_o,
    input wire logic       irq_pad_oe_o,
    input wire pin_vec_t   func_in_o,
    input wire logic       chain_mode_o
);
    // Reference chain and low-prefix test
    function automatic logic chain_f(pin_vec_t p);
        logic s = 1'b1;
        for (int i = 0; i < CHAIN_LEN; i++) s = ~(s & p[i]);
        return ~s;
    endfunction : chain_f
    function automatic logic pre_f(pin_vec_t p);
        return (~p & (~p + 17'h1)) == 17'h0;
    endfunction : pre_f
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Boundary pin of a low prefix moves; others would mask the toggle
    sequence s_step;
        $past(chain_mode_o) && $countones(pad_in_i ^ $past(pad_in_i)) == 1
            && pre_f(pad_in_i) && pre_f($past(pad_in_i));
    endsequence
    a_chain_value: assert property (chain_mode_o |=>
        irq_pad_o == chain_f($past(pad_in_i))) else $error("chain value");
    a_pins_quiet: assert property (chain_mode_o |=>
        pad_o.oe == '0 && irq_pad_oe_o) else $error("pin driven");
    a_core_blocked: assert property (chain_mode_o |=>
        func_in_o == PIN_ALL_ON) else $error("core sees pins");
    a_mode_holds: assert property (chain_mode_o |=> chain_mode_o)
        else $error("mode dropped");
    a_strap_entry: assert property ($rose(chain_mode_o) |->
        {$past(pad_in_i[IDX_LAMP_G2_B]), $past(pad_in_i[IDX_LAMP_G2_A]),
         $past(pad_in_i[IDX_LAMP_G4_A])}
        == CHAIN_STRAP) else $error("mode without strap");
    a_all_high: assert property (chain_mode_o && pad_in_i == PIN_ALL_ON
        |=> irq_pad_o) else $error("all high gives low");
    a_step_toggle: assert property (s_step |=> $changed(irq_pad_o))
        else $error("no toggle");
endmodule : io_nand_chain_test_properties

// ### test/board_tester_model.sv
// Board tester that drives the chain pins and watches the output
`timescale 1ns/1ps
module board_tester_model
    import nand_chain_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire strap_t     strap_i,
    input  wire logic [4:0] steps_i,
    input  wire logic       irq_i,
    output pin_vec_t        pins_o,
    output logic            fault_o
);
    logic       live_r;
    logic       base_r;
    logic       pend_r;
    logic [4:0] k_r;
    // Straps stay up through the first edge after reset, then steps
    assign pins_o = live_r ? PIN_ALL_ON << steps_i
        : {10'h3ff, strap_i[2:1], 4'hf, strap_i[0]};
    // Output before a step is kept; one edge later it must have moved
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            live_r  <= 1'b0;
            base_r  <= 1'b0;
            pend_r  <= 1'b0;
            k_r     <= 5'h0;
            fault_o <= 1'b0;
        end else begin
            live_r <= 1'b1;
            k_r    <= steps_i;
            pend_r <= (k_r != steps_i);
            if (k_r != steps_i) begin
                base_r <= irq_i;
            end
            if (pend_r && irq_i == base_r) begin
                fault_o <= 1'b1;
            end
        end
    end
endmodule : board_tester_model

// ### test/io_nand_chain_test_bench.sv
// Bench for the pin chain test block
`timescale 1ns/1ps
module io_nand_chain_test_bench;
    import nand_chain_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    strap_t     strap     = CHAIN_STRAP;
    logic [4:0] steps     = 5'h0;
    pin_vec_t   pins, func_in_o;
    pad_drive_s pad_o;
    logic       irq_pad_o, irq_pad_oe_o, chain_mode_o, fault;
    int         n_errors = 0;
    int         checks_done = 0;
    // Core drive held active so any leak shows at the pins
    io_nand_chain_test u_dut (.ref_clk_i, .arst_n_i, .pad_in_i(pins), .pad_o,
        .irq_pad_o, .irq_pad_oe_o, .func_drive_i({PIN_ALL_ON, PIN_ALL_ON}),
        .func_irq_n_i(1'b0), .func_in_o, .chain_mode_o);
    board_tester_model u_tester (.ref_clk_i, .arst_n_i, .strap_i(strap),
        .steps_i(steps), .irq_i(irq_pad_o), .pins_o(pins), .fault_o(fault));
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    task automatic chk(input string nm, input pin_vec_t e, input pin_vec_t g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc
    task automatic do_reset(input strap_t s);
        strap = s;
        steps = 5'h0;
        arst_n_i = 1'b0;
        cyc(16);
        arst_n_i = 1'b1;
        cyc(3);
    endtask : do_reset
    task automatic t_entry();
        do_reset(CHAIN_STRAP);
        chk("mode", 1'b1, chain_mode_o);
        chk("pad_oe", PIN_ALL_OFF, pad_o.oe);
        chk("pad_dat", PIN_ALL_OFF, pad_o.dat);
        chk("irq_oe", 1'b1, irq_pad_oe_o);
        chk("func_in", PIN_ALL_ON, func_in_o);
        $display("t_entry done");
    endtask : t_entry
    task automatic t_walk();
        for (int k = 0; k <= CHAIN_LEN; k++) begin
            steps = 5'(k);
            cyc(5);
            chk("irq", k % 2 == 0, irq_pad_o);
        end
        chk("fault", 1'b0, fault);
        $display("t_walk done");
    endtask : t_walk
    task automatic t_no_strap();
        do_reset(3'h7);
        chk("mode", 1'b0, chain_mode_o);
        chk("pad_oe", PIN_ALL_ON, pad_o.oe);
        chk("pad_dat", PIN_ALL_ON, pad_o.dat);
        chk("irq", 1'b0, irq_pad_o);
        chk("irq_oe", 1'b1, irq_pad_oe_o);
        chk("func_in", PIN_ALL_ON, func_in_o);
        $display("t_no_strap done");
    endtask : t_no_strap
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Watchdog well past the roughly 130 cycles of the tests
    initial begin
        #10000;
        n_errors++;
        stop_test();
    end
    initial begin
        t_entry();
        t_walk();
        t_no_strap();
        stop_test();
    end
endmodule : io_nand_chain_test_bench
bind io_nand_chain_test io_nand_chain_test_properties u_props (.ref_clk_i,
    .arst_n_i, .pad_in_i, .pad_o, .irq_pad_o, .irq_pad_oe_o, .func_in_o,
    .chain_mode_o);
